// file: hdl/ascp_pkg.sv
// shared constants and types for the ascii command parser
package ascp_pkg;

	// ------------------------------------------------------------
	// reserved words
	// ------------------------------------------------------------
	localparam int ASCP_NUM_WORDS = 8;
	localparam logic [2:0] ASCP_W_CON = 3'h0;
	localparam logic [2:0] ASCP_W_REA = 3'h1;
	localparam logic [2:0] ASCP_W_SAM = 3'h2;
	localparam logic [2:0] ASCP_W_SET = 3'h3;
	localparam logic [2:0] ASCP_W_WRI = 3'h4;
	localparam logic [2:0] ASCP_W_INP = 3'h5;
	localparam logic [2:0] ASCP_W_OUT = 3'h6;
	localparam logic [2:0] ASCP_W_NON = 3'h7;
	// text is space padded; only the first LEN characters are compared
	localparam logic [9:0][7:0] ASCP_WORD_TEXT [ASCP_NUM_WORDS] = '{
		"CONFIGURE ", "READ      ", "SAMPLE    ", "SET       ",
		"WRITE     ", "INPUT     ", "OUTPUT    ", "NONCLOCKED"};
	localparam logic [3:0] ASCP_WORD_LEN [ASCP_NUM_WORDS] = '{
		4'h9, 4'h4, 4'h6, 4'h3, 4'h5, 4'h5, 4'h6, 4'ha};
	localparam logic [3:0] ASCP_MIN_ABBREV = 4'h3;

	// elements expected after each command word
	localparam logic [2:0] ASCP_ARGS_CON = 3'h3;
	localparam logic [2:0] ASCP_ARGS_REA = 3'h1;
	localparam logic [2:0] ASCP_ARGS_SAM = 3'h1;
	localparam logic [2:0] ASCP_ARGS_SET = 3'h2;
	localparam logic [2:0] ASCP_ARGS_WRI = 3'h2;

	// ------------------------------------------------------------
	// characters
	// ------------------------------------------------------------
	localparam logic [7:0] ASCP_CH_LF = 8'h0a;
	localparam logic [7:0] ASCP_CH_CR = 8'h0d;
	localparam logic [7:0] ASCP_CH_COMMA = 8'h2c;
	localparam logic [7:0] ASCP_CH_SPACE = 8'h20;
	localparam logic [7:0] ASCP_CH_DEL = 8'h7f;
	localparam logic [7:0] ASCP_CH_LOW_A = 8'h61;
	localparam logic [7:0] ASCP_CH_LOW_Z = 8'h7a;
	localparam logic [7:0] ASCP_CH_UP_A = 8'h41;
	localparam logic [7:0] ASCP_CH_UP_Z = 8'h5a;
	localparam logic [7:0] ASCP_CH_UP_B = 8'h42;
	localparam logic [7:0] ASCP_CH_DIG_0 = 8'h30;
	localparam logic [7:0] ASCP_CH_DIG_9 = 8'h39;
	localparam logic [7:0] ASCP_CASE_BIT = 8'h20;

	// ------------------------------------------------------------
	// data limits and status
	// ------------------------------------------------------------
	localparam logic [11:0] ASCP_DEC_MAX = 12'h0ff;
	localparam logic [11:0] ASCP_DEC_RADIX = 12'h00a;
	localparam logic [3:0] ASCP_BIN_DIGITS = 4'h4;
	localparam int ASCP_ERR_BIT = 2;
	localparam logic [7:0] ASCP_STATUS_RST = 8'h00;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PS_RUN = 2'b01, PS_SKIP = 2'b10} ascp_pstate_type;
	typedef enum logic [2:0] {EK_NONE = 3'b001, EK_WORD = 3'b010, EK_NUM = 3'b100} ascp_kind_type;
	typedef enum logic [3:0] {
		RS_IDLE = 4'b0001, RS_DATA = 4'b0010, RS_CR = 4'b0100, RS_LF = 4'b1000
	} ascp_rstate_type;

endpackage

// file: hdl/ascp_word_match.sv
// candidate tracker matching a word against all reserved words
`timescale 1ns/1ps
`default_nettype none
module ascp_word_match #(
	parameter int NUM_WORDS = ascp_pkg::ASCP_NUM_WORDS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wordStart,
	input wire logic wordStep,
	input wire logic [7:0] wordChar,
	input wire logic [3:0] charPos,
	output logic [NUM_WORDS-1:0] candMask
);
	logic [NUM_WORDS-1:0] charHit;
	logic [NUM_WORDS-1:0] candMask_r;
	logic [NUM_WORDS-1:0] candMask_nxt;

	// a character past the word's length never matches, so over-long words drop out
	for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
		assign charHit[w] = (charPos < ascp_pkg::ASCP_WORD_LEN[w]) &&
			(wordChar == ascp_pkg::ASCP_WORD_TEXT[w][4'h9 - charPos]);
	end

	always_comb begin
		candMask_nxt = candMask_r;
		if (wordStart) begin
			candMask_nxt = charHit;
		end else if (wordStep) begin
			candMask_nxt = candMask_r & charHit;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			candMask_r <= '0;
		end else begin
			candMask_r <= candMask_nxt;
		end
	end

	assign candMask = candMask_r;

	a_mask_narrows: assert property (@(posedge core_clk) disable iff (sys_rst)
		wordStep |=> (candMask & ~$past(candMask)) == '0)
		else $error("word candidate reappeared");
endmodule
`default_nettype wire

// file: hdl/ascp_command_parser.sv
// ascii command parser with response framing for the host command interface
//
// Summary of operation
// - words may be shortened, keeping at least their first three characters
// - commands CONFIGURE READ SAMPLE SET WRITE; keywords only after CONFIGURE
// - a misspelled word discards the command
// - bad word, out of range data or wrong element count flags an input error
// - on error abandon the command and wait for a fresh one
// - every input error sets bit 2 of the serial poll status byte
// - sample and read answers end with carriage return then line feed
// - answers on the gpib port also carry the end message
// - words match regardless of letter case
// - spaces and non printables other than line feed are dropped
// - comma and line feed delimit; runs count once; first may be absent
// - data is decimal 0 to 255 or binary 0000b to 1111b
`timescale 1ns/1ps
`default_nettype none
module ascp_command_parser (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxFromGpib,
	output logic cmdValid,
	output logic [2:0] cmdWord,
	output logic [7:0] cmdData0,
	output logic [7:0] cmdData1,
	output logic [2:0] cmdKey0,
	output logic [2:0] cmdKey1,
	output logic inputErr,
	input wire logic serialPollAck,
	output logic [7:0] statusByte,
	input wire logic respValid,
	input wire logic [7:0] respData,
	input wire logic respLast,
	output logic respReady,
	output logic txValid,
	output logic [7:0] txData,
	output logic txEnd,
	output logic txGpib,
	input wire logic txReady
);
	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] argsOf(input logic [2:0] word);
		case (word)
			ascp_pkg::ASCP_W_CON: argsOf = ascp_pkg::ASCP_ARGS_CON;
			ascp_pkg::ASCP_W_REA: argsOf = ascp_pkg::ASCP_ARGS_REA;
			ascp_pkg::ASCP_W_SAM: argsOf = ascp_pkg::ASCP_ARGS_SAM;
			ascp_pkg::ASCP_W_SET: argsOf = ascp_pkg::ASCP_ARGS_SET;
			ascp_pkg::ASCP_W_WRI: argsOf = ascp_pkg::ASCP_ARGS_WRI;
			default: argsOf = 3'h0;
		endcase
	endfunction

	function automatic logic [2:0] firstHit(input logic [7:0] mask);
		firstHit = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (mask[i]) begin
				firstHit = 3'(i);
			end
		end
	endfunction

	// ------------------------------------------------------------
	// character classes
	// ------------------------------------------------------------
	logic [7:0] upChar;
	logic isLf, isComma, isDelim, isIgnored, isLetter, isDigit;
	assign upChar = (rxData >= ascp_pkg::ASCP_CH_LOW_A && rxData <= ascp_pkg::ASCP_CH_LOW_Z) ?
		(rxData & ~ascp_pkg::ASCP_CASE_BIT) : rxData;
	assign isLf = rxData == ascp_pkg::ASCP_CH_LF;
	assign isComma = rxData == ascp_pkg::ASCP_CH_COMMA;
	assign isDelim = isLf || isComma;
	assign isIgnored = !isLf && (rxData <= ascp_pkg::ASCP_CH_SPACE ||
		rxData >= ascp_pkg::ASCP_CH_DEL);
	assign isLetter = upChar >= ascp_pkg::ASCP_CH_UP_A && upChar <= ascp_pkg::ASCP_CH_UP_Z;
	assign isDigit = rxData >= ascp_pkg::ASCP_CH_DIG_0 && rxData <= ascp_pkg::ASCP_CH_DIG_9;

	// ------------------------------------------------------------
	// parser state
	// ------------------------------------------------------------
	ascp_pkg::ascp_pstate_type pState_r, pState_nxt;
	ascp_pkg::ascp_kind_type kind_r, kind_nxt;
	logic [3:0] len_r, len_nxt, digits_r, digits_nxt, bin_r, bin_nxt;
	logic [2:0] idx_r, idx_nxt, cmd_r, cmd_nxt, k0_r, k0_nxt, k1_r, k1_nxt;
	logic [7:0] d0_r, d0_nxt, d1_r, d1_nxt, dec_r, dec_nxt;
	logic over_r, over_nxt, allBin_r, allBin_nxt, sfx_r, sfx_nxt;
	logic cmdValid_r, cmdValid_nxt, err_r, errFlag_r, errFlag_nxt, lastGpib_r, lastGpib_nxt;
	logic wordStart, wordStep, endElem, elemBad, charErr, errNow, hitOk, numOk;
	logic [2:0] hitIdx, cmdAfter, idxAfter;
	logic [7:0] candMask, numVal;
	logic [11:0] decWide;

	ascp_word_match u_match (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.wordStart(wordStart),
		.wordStep(wordStep),
		.wordChar(upChar),
		.charPos(wordStart ? 4'h0 : len_r),
		.candMask(candMask)
	);

	assign hitIdx = firstHit(candMask);
	assign hitOk = (|candMask) && len_r >= ascp_pkg::ASCP_MIN_ABBREV;
	assign numOk = sfx_r ? (allBin_r && digits_r <= ascp_pkg::ASCP_BIN_DIGITS) : !over_r;
	assign numVal = sfx_r ? {4'h0, bin_r} : dec_r;
	assign decWide = 12'(dec_r) * ascp_pkg::ASCP_DEC_RADIX + 12'(rxData[3:0]);

	always_comb begin
		pState_nxt = pState_r;
		kind_nxt = kind_r;
		len_nxt = len_r;
		digits_nxt = digits_r;
		bin_nxt = bin_r;
		idx_nxt = idx_r;
		cmd_nxt = cmd_r;
		k0_nxt = k0_r;
		k1_nxt = k1_r;
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		dec_nxt = dec_r;
		over_nxt = over_r;
		allBin_nxt = allBin_r;
		sfx_nxt = sfx_r;
		lastGpib_nxt = lastGpib_r;
		cmdValid_nxt = 1'b0;
		wordStart = 1'b0;
		wordStep = 1'b0;
		elemBad = 1'b0;
		charErr = 1'b0;
		cmdAfter = cmd_r;
		idxAfter = idx_r;
		// a digit right after a word closes it without a delimiter
		endElem = rxValid && pState_r == ascp_pkg::PS_RUN && !isIgnored &&
			((isDelim && kind_r != ascp_pkg::EK_NONE) ||
			(isDigit && kind_r == ascp_pkg::EK_WORD));
		if (endElem) begin
			idxAfter = idx_r + 3'h1;
			kind_nxt = ascp_pkg::EK_NONE;
			if (idx_r == 3'h0) begin
				elemBad = !(kind_r == ascp_pkg::EK_WORD && hitOk &&
					hitIdx <= ascp_pkg::ASCP_W_WRI);
				cmdAfter = hitIdx;
			end else if (idx_r > argsOf(cmd_r)) begin
				elemBad = 1'b1;
			end else if (cmd_r == ascp_pkg::ASCP_W_CON && idx_r >= 3'h2) begin
				elemBad = !(kind_r == ascp_pkg::EK_WORD && hitOk &&
					hitIdx >= ascp_pkg::ASCP_W_INP);
				if (idx_r == 3'h2) begin
					k0_nxt = hitIdx;
				end else begin
					k1_nxt = hitIdx;
				end
			end else begin
				elemBad = !(kind_r == ascp_pkg::EK_NUM && numOk);
				if (idx_r == 3'h1) begin
					d0_nxt = numVal;
				end else begin
					d1_nxt = numVal;
				end
			end
			idx_nxt = idxAfter;
			cmd_nxt = cmdAfter;
		end
		if (rxValid) begin
			case (pState_r)
				ascp_pkg::PS_SKIP: begin
					if (isLf) begin
						pState_nxt = ascp_pkg::PS_RUN;
					end
				end
				ascp_pkg::PS_RUN: begin
					if (isLetter) begin
						if (kind_r == ascp_pkg::EK_NUM) begin
							if (upChar == ascp_pkg::ASCP_CH_UP_B && !sfx_r) begin
								sfx_nxt = 1'b1;
							end else begin
								charErr = 1'b1;
							end
						end else if (kind_r == ascp_pkg::EK_WORD) begin
							wordStep = 1'b1;
							len_nxt = (len_r == 4'hf) ? len_r : len_r + 4'h1;
						end else begin
							wordStart = 1'b1;
							kind_nxt = ascp_pkg::EK_WORD;
							len_nxt = 4'h1;
						end
					end else if (isDigit) begin
						if (kind_r == ascp_pkg::EK_NUM) begin
							charErr = sfx_r;
							dec_nxt = decWide[7:0];
							over_nxt = over_r || decWide > ascp_pkg::ASCP_DEC_MAX;
							bin_nxt = {bin_r[2:0], rxData[0]};
							allBin_nxt = allBin_r && rxData[3:1] == 3'h0;
							digits_nxt = (digits_r == 4'hf) ? digits_r : digits_r + 4'h1;
						end else begin
							kind_nxt = ascp_pkg::EK_NUM;
							dec_nxt = {4'h0, rxData[3:0]};
							over_nxt = 1'b0;
							bin_nxt = {3'h0, rxData[0]};
							allBin_nxt = rxData[3:1] == 3'h0;
							digits_nxt = 4'h1;
							sfx_nxt = 1'b0;
						end
					end else if (isDelim) begin
						if (!elemBad && idxAfter == argsOf(cmdAfter) + 3'h1) begin
							cmdValid_nxt = 1'b1;
							idx_nxt = 3'h0;
							if (cmdAfter == ascp_pkg::ASCP_W_REA ||
								cmdAfter == ascp_pkg::ASCP_W_SAM) begin
								lastGpib_nxt = rxFromGpib;
							end
						end else if (isLf && idxAfter != 3'h0) begin
							charErr = 1'b1;
						end
					end else if (!isIgnored) begin
						charErr = 1'b1;
					end
				end
				default: pState_nxt = ascp_pkg::PS_RUN;
			endcase
		end
		errNow = charErr || elemBad;
		if (errNow) begin
			cmdValid_nxt = 1'b0;
			kind_nxt = ascp_pkg::EK_NONE;
			idx_nxt = 3'h0;
			// the line feed that exposed the error already ends the command
			pState_nxt = isLf ? ascp_pkg::PS_RUN : ascp_pkg::PS_SKIP;
		end
		// a new error wins over a poll that clears the same cycle
		errFlag_nxt = errNow || (errFlag_r && !serialPollAck);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pState_r <= ascp_pkg::PS_RUN;
			kind_r <= ascp_pkg::EK_NONE;
			{len_r, digits_r, bin_r} <= 12'h000;
			{idx_r, cmd_r, k0_r, k1_r} <= 12'h000;
			{d0_r, d1_r, dec_r} <= 24'h000000;
			{over_r, allBin_r, sfx_r} <= 3'h0;
			{cmdValid_r, err_r, errFlag_r, lastGpib_r} <= 4'h0;
		end else begin
			pState_r <= pState_nxt;
			kind_r <= kind_nxt;
			{len_r, digits_r, bin_r} <= {len_nxt, digits_nxt, bin_nxt};
			{idx_r, cmd_r, k0_r, k1_r} <= {idx_nxt, cmd_nxt, k0_nxt, k1_nxt};
			{d0_r, d1_r, dec_r} <= {d0_nxt, d1_nxt, dec_nxt};
			{over_r, allBin_r, sfx_r} <= {over_nxt, allBin_nxt, sfx_nxt};
			{cmdValid_r, err_r, errFlag_r, lastGpib_r} <=
				{cmdValid_nxt, errNow, errFlag_nxt, lastGpib_nxt};
		end
	end

	// fields only hold while cmdValid is high; parsing may overwrite them after
	assign cmdValid = cmdValid_r;
	assign cmdWord = cmd_r;
	assign cmdData0 = d0_r;
	assign cmdData1 = d1_r;
	assign cmdKey0 = k0_r;
	assign cmdKey1 = k1_r;
	assign inputErr = err_r;
	assign statusByte = ascp_pkg::ASCP_STATUS_RST |
		({7'h00, errFlag_r} << ascp_pkg::ASCP_ERR_BIT);

	// ------------------------------------------------------------
	// response framing
	// ------------------------------------------------------------
	ascp_pkg::ascp_rstate_type rState_r, rState_nxt;
	logic txValid_r, txValid_nxt, txEnd_r, txEnd_nxt, respGpib_r, respGpib_nxt, slotFree;
	logic [7:0] txData_r, txData_nxt;

	assign slotFree = !txValid_r || txReady;
	assign respReady = rState_r == ascp_pkg::RS_DATA && slotFree;

	always_comb begin
		rState_nxt = rState_r;
		txValid_nxt = txValid_r && !txReady;
		txData_nxt = txData_r;
		txEnd_nxt = txEnd_r;
		respGpib_nxt = respGpib_r;
		case (rState_r)
			ascp_pkg::RS_IDLE: begin
				// wait for the previous line feed so txGpib stays with its frame
				if (respValid && !txValid_r) begin
					rState_nxt = ascp_pkg::RS_DATA;
					respGpib_nxt = lastGpib_r;
				end
			end
			ascp_pkg::RS_DATA: begin
				if (respValid && slotFree) begin
					txValid_nxt = 1'b1;
					txData_nxt = respData;
					txEnd_nxt = 1'b0;
					if (respLast) begin
						rState_nxt = ascp_pkg::RS_CR;
					end
				end
			end
			ascp_pkg::RS_CR: begin
				if (slotFree) begin
					txValid_nxt = 1'b1;
					txData_nxt = ascp_pkg::ASCP_CH_CR;
					txEnd_nxt = 1'b0;
					rState_nxt = ascp_pkg::RS_LF;
				end
			end
			ascp_pkg::RS_LF: begin
				if (slotFree) begin
					txValid_nxt = 1'b1;
					txData_nxt = ascp_pkg::ASCP_CH_LF;
					txEnd_nxt = respGpib_r;
					rState_nxt = ascp_pkg::RS_IDLE;
				end
			end
			default: rState_nxt = ascp_pkg::RS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rState_r <= ascp_pkg::RS_IDLE;
			{txValid_r, txEnd_r, respGpib_r} <= 3'h0;
			txData_r <= 8'h00;
		end else begin
			rState_r <= rState_nxt;
			{txValid_r, txEnd_r, respGpib_r} <= {txValid_nxt, txEnd_nxt, respGpib_nxt};
			txData_r <= txData_nxt;
		end
	end

	assign txValid = txValid_r;
	assign txData = txData_r;
	assign txEnd = txEnd_r;
	assign txGpib = respGpib_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_err_sets_status: assert property (errNow |=> inputErr && statusByte[2])
		else $error("input error not reported in status");
	a_err_aborts_cmd: assert property (errNow && !isLf |=>
		pState_r == ascp_pkg::PS_SKIP && !cmdValid)
		else $error("command not abandoned after error");
	a_skip_holds: assert property (pState_r == ascp_pkg::PS_SKIP &&
		!(rxValid && isLf) |=> pState_r == ascp_pkg::PS_SKIP && !cmdValid)
		else $error("left skip without line feed");
	a_short_word_err: assert property (endElem && kind_r == ascp_pkg::EK_WORD &&
		len_r < ascp_pkg::ASCP_MIN_ABBREV |-> errNow)
		else $error("word under three characters accepted");
	a_cmd_word_known: assert property (cmdValid |-> cmdWord <= ascp_pkg::ASCP_W_WRI &&
		$past(pState_r) == ascp_pkg::PS_RUN)
		else $error("emitted command is not a command word");
	a_ignored_char: assert property (rxValid && isIgnored &&
		pState_r == ascp_pkg::PS_RUN |=> $stable(kind_r) && $stable(idx_r) && !inputErr)
		else $error("ignored character changed parser state");
	a_delim_run: assert property (rxValid && isComma && kind_r == ascp_pkg::EK_NONE &&
		pState_r == ascp_pkg::PS_RUN |-> !errNow ##1 !cmdValid)
		else $error("repeated delimiter not absorbed");
	a_dec_range: assert property (endElem && kind_r == ascp_pkg::EK_NUM && !sfx_r &&
		over_r |=> inputErr)
		else $error("decimal above range accepted");
	a_cr_then_lf: assert property (rState_r == ascp_pkg::RS_CR && slotFree |=>
		txValid && txData == ascp_pkg::ASCP_CH_CR ##1
		txValid && (txData == ascp_pkg::ASCP_CH_LF || !$past(txReady)))
		else $error("carriage return not followed by line feed");
	a_end_on_lf: assert property (txValid && txEnd |->
		txData == ascp_pkg::ASCP_CH_LF && txGpib)
		else $error("end message outside gpib line feed");
endmodule
`default_nettype wire

// file: verification/ascp_host_model.sv
// host computer model: sends command text and takes answer characters
`timescale 1ns/1ps
`default_nettype none
module ascp_host_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	output logic rxValid,
	output logic [7:0] rxData,
	output logic rxFromGpib,
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txEnd,
	input wire logic txGpib,
	output logic txReady
);
	logic slowSink;
	logic [9:0] gotQ[$];

	initial begin
		rxValid = 1'b0;
		rxData = 8'h00;
		rxFromGpib = 1'b0;
		txReady = 1'b0;
		slowSink = 1'b0;
	end

	// one character per edge, back to back, as a fast terminal would
	task automatic sendStr(input string s, input logic gpib);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge core_clk);
			rxValid <= 1'b1;
			rxData <= s[i];
			rxFromGpib <= gpib;
		end
		@(posedge core_clk);
		rxValid <= 1'b0;
		// idle line must not keep looking like the last character
		rxData <= ~rxData;
		rxFromGpib <= ~gpib;
	endtask

	// slow sink accepts only every other cycle
	always @(posedge core_clk) begin
		if (sys_rst)
			txReady <= 1'b0;
		else
			txReady <= slowSink ? ~txReady : 1'b1;
		if (!sys_rst && txValid === 1'b1 && txReady === 1'b1)
			gotQ.push_back({txEnd, txGpib, txData});
	end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking testbench for the ascii command parser
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk, sys_rst, rxValid, rxFromGpib, serialPollAck;
	logic respValid, respLast, respReady, cmdValid, inputErr;
	logic txValid, txEnd, txGpib, txReady;
	logic [7:0] rxData, respData, txData, cmdData0, cmdData1, statusByte;
	logic [2:0] cmdWord, cmdKey0, cmdKey1;
	int errorCnt, nCompared, nErr, cycles;
	logic [24:0] cmdQ[$];

	ascp_command_parser i_ascp_command_parser (.core_clk(core_clk), .sys_rst(sys_rst),
		.rxValid(rxValid), .rxData(rxData), .rxFromGpib(rxFromGpib), .cmdValid(cmdValid),
		.cmdWord(cmdWord), .cmdData0(cmdData0), .cmdData1(cmdData1), .cmdKey0(cmdKey0),
		.cmdKey1(cmdKey1), .inputErr(inputErr), .serialPollAck(serialPollAck),
		.statusByte(statusByte), .respValid(respValid), .respData(respData),
		.respLast(respLast), .respReady(respReady), .txValid(txValid), .txData(txData),
		.txEnd(txEnd), .txGpib(txGpib), .txReady(txReady));

	ascp_host_model u_host (.core_clk(core_clk), .sys_rst(sys_rst), .rxValid(rxValid),
		.rxData(rxData), .rxFromGpib(rxFromGpib), .txValid(txValid), .txData(txData),
		.txEnd(txEnd), .txGpib(txGpib), .txReady(txReady));

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	task automatic results();
		if (errorCnt == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// monitor samples the pre-edge values the design itself presents
	always @(posedge core_clk) begin
		if (!sys_rst && cmdValid === 1'b1)
			cmdQ.push_back({cmdWord, cmdData0, cmdData1, cmdKey0, cmdKey1});
		if (!sys_rst && inputErr === 1'b1)
			nErr++;
		cycles++;
		if (cycles == 20000) begin
			errorCnt++;
			results();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			errorCnt++;
		end
	endtask

	task automatic sendLine(input string s, input logic gpib);
		nErr = 0;
		cmdQ.delete();
		u_host.sendStr(s, gpib);
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	task automatic popCmd(input logic [2:0] w, input logic [7:0] d0, input logic [7:0] d1,
		input logic [2:0] k0, input logic [2:0] k1);
		logic [24:0] r;
		chk("command present", 1, cmdQ.size() > 0);
		if (cmdQ.size() > 0) begin
			r = cmdQ.pop_front();
			chk("cmdWord", w, r[24:22]);
			chk("cmdData0", d0, r[21:14]);
			if (w == 3'h3 || w == 3'h4)
				chk("cmdData1", d1, r[13:6]);
			if (w == 3'h0)
				chk("cmdKey0 cmdKey1", {k0, k1}, r[5:0]);
		end
	endtask

	task automatic goodCmd(input string s, input logic [2:0] w, input logic [7:0] d0,
		input logic [7:0] d1, input logic [2:0] k0, input logic [2:0] k1);
		sendLine(s, 1'b0);
		popCmd(w, d0, d1, k0, k1);
		chk("extra commands", 0, cmdQ.size());
		chk("inputErr count", 0, nErr);
	endtask

	// every bad line gives one error, no command, sticky status until polled
	task automatic badCmd(input string s);
		sendLine(s, 1'b0);
		chk("inputErr count", 1, nErr);
		chk("command count", 0, cmdQ.size());
		chk("statusByte after error", 8'h04, statusByte);
		@(posedge core_clk);
		serialPollAck <= 1'b1;
		@(posedge core_clk);
		serialPollAck <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("statusByte after poll", 8'h00, statusByte);
	endtask

	task automatic respTest(input string cmd, input logic gpib, input logic [2:0] w,
		input string resp, input logic slow);
		logic [9:0] g;
		int n;
		sendLine(cmd, gpib);
		popCmd(w, 8'h01, 8'h00, 3'h0, 3'h0);
		u_host.slowSink = slow;
		u_host.gotQ.delete();
		@(posedge core_clk);
		for (int i = 0; i < resp.len(); i++) begin
			respValid <= 1'b1;
			respData <= resp[i];
			respLast <= (i == resp.len() - 1);
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (respReady !== 1'b1 && n < 100);
		end
		respValid <= 1'b0;
		respData <= ~respData;
		respLast <= 1'b0;
		n = 0;
		while (u_host.gotQ.size() < resp.len() + 2 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		repeat (4) @(posedge core_clk);
		chk("answer length", resp.len() + 2, u_host.gotQ.size());
		for (int i = 0; i < resp.len() + 2 && u_host.gotQ.size() > 0; i++) begin
			g = u_host.gotQ.pop_front();
			if (i < resp.len())
				chk("answer char", {2'b0, gpib, resp[i]}, g);
			else if (i == resp.len())
				chk("answer cr", {2'b0, gpib, 8'h0d}, g);
			else
				chk("answer lf end", {gpib, gpib, 8'h0a}, g);
		end
		u_host.slowSink = 1'b0;
	endtask

	initial begin
		errorCnt = 0;
		nCompared = 0;
		cycles = 0;
		nErr = 0;
		sys_rst = 1'b1;
		serialPollAck = 1'b0;
		respValid = 1'b0;
		respData = 8'h00;
		respLast = 1'b0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("statusByte reset", 8'h00, statusByte);
		chk("txValid reset", 0, txValid);
		chk("respReady reset", 0, respReady);
		goodCmd("SET 1,2\n", 3'h3, 8'h01, 8'h02, 3'h0, 3'h0);
		goodCmd("set,0,255\n", 3'h3, 8'h00, 8'hff, 3'h0, 3'h0);
		goodCmd("S E\011T\015 7,8\015\n", 3'h3, 8'h07, 8'h08, 3'h0, 3'h0);
		goodCmd("SET,,1,,2\n\n", 3'h3, 8'h01, 8'h02, 3'h0, 3'h0);
		goodCmd("CONFIGURE6,INPUT,NONCLOCKED\n", 3'h0, 8'h06, 8'h00, 3'h5, 3'h7);
		goodCmd("con 9,Out,non\n", 3'h0, 8'h09, 8'h00, 3'h6, 3'h7);
		goodCmd("CONF1,INPU,OUTPUT\n", 3'h0, 8'h01, 8'h00, 3'h5, 3'h6);
		goodCmd("READ3\n", 3'h1, 8'h03, 8'h00, 3'h0, 3'h0);
		goodCmd("SAMPLE2\n", 3'h2, 8'h02, 8'h00, 3'h0, 3'h0);
		goodCmd("sam5\n", 3'h2, 8'h05, 8'h00, 3'h0, 3'h0);
		goodCmd("WRITE4,1111B\n", 3'h4, 8'h04, 8'h0f, 3'h0, 3'h0);
		goodCmd("WRI5,0000b\n", 3'h4, 8'h05, 8'h00, 3'h0, 3'h0);
		sendLine("WRITE4,1001B,WRITE5,0110B\n", 1'b0);
		popCmd(3'h4, 8'h04, 8'h09, 3'h0, 3'h0);
		popCmd(3'h4, 8'h05, 8'h06, 3'h0, 3'h0);
		badCmd("XYZ1\n");
		badCmd("SE1,2\n");
		badCmd("SETT1,2\n");
		badCmd("SET 1,256\n");
		badCmd("WRITE4,10000B\n");
		badCmd("SET1\n");
		badCmd("SET INP,2\n");
		badCmd("CON6,SAM,NON\n");
		badCmd("QQQ,SET3,4\n");
		goodCmd("WRI 2,3\n", 3'h4, 8'h02, 8'h03, 3'h0, 3'h0);
		respTest("REA1\n", 1'b1, 3'h1, "7A", 1'b0);
		respTest("sam1\n", 1'b0, 3'h2, "5", 1'b1);
		results();
	end
endmodule
`default_nettype wire
